// ---- address_breakpoint_unit.sv ----
// address breakpoint unit with axi4-lite register slave
`timescale 1ns/1ps
module address_breakpoint_unit (
  input wire logic clk_in,
  input wire logic rst_in,
  // axi4-lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  // axi4-lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // axi4-lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // axi4-lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  // axi4-lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // cpu side
  input wire break_unit_pkg::cpu_bus_t cpu_in,
  output break_unit_pkg::core_ctrl_t core_out,
  // interrupt level
  output logic irq_out
);

  // decode: is the offset a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    if (a == break_unit_pkg::OFF_STATUS_CONTROL) begin
      return 1'b1;
    end else if (a == break_unit_pkg::OFF_ADDR_HIGH) begin
      return 1'b1;
    end else if (a == break_unit_pkg::OFF_ADDR_LOW) begin
      return 1'b1;
    end else if (a == break_unit_pkg::OFF_IRQ_STATUS) begin
      return 1'b1;
    end else if (a == break_unit_pkg::OFF_IRQ_MASK) begin
      return 1'b1;
    end else if (a == break_unit_pkg::OFF_FLAG_CONTROL) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // registers
  logic enable_reg; // break enable bit
  logic active_reg; // break active bit
  logic [7:0] addr_high_reg; // break address upper byte
  logic [7:0] addr_low_reg; // break address lower byte
  logic [1:0] irq_status_reg; // sticky events
  logic [1:0] irq_mask_reg; // event mask
  logic flag_clear_enable_reg; // flag clear enable in break
  logic armed_reg; // match allowed for current address
  break_unit_pkg::break_state_t state_reg; // break sequencer
  break_unit_pkg::break_state_t state_next;

  // write channel holding registers
  logic aw_held_reg; // address taken, waiting
  logic w_held_reg; // data taken, waiting
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // write commit when both halves are held
  logic wr_do;
  logic wr_lane0;
  logic [7:0] wr_byte;
  logic sw_trigger; // software write of one to active bit
  logic sw_clear_active; // software write of zero to active bit
  logic addr_written; // either address byte written

  // match and break events
  logic addr_match;
  logic hw_match;
  logic break_taken; // entry into break sequence
  logic break_exit; // return from interrupt ends break

  // write path decode
  assign wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  assign wr_lane0 = wr_do && w_strb_reg[0];
  assign wr_byte = w_data_reg[7:0];
  // RQ4: software write triggers break
  assign sw_trigger = wr_lane0 &&
    (aw_addr_reg == break_unit_pkg::OFF_STATUS_CONTROL) &&
    wr_byte[break_unit_pkg::BIT_ACTIVE];
  assign sw_clear_active = wr_lane0 &&
    (aw_addr_reg == break_unit_pkg::OFF_STATUS_CONTROL) &&
    !wr_byte[break_unit_pkg::BIT_ACTIVE];
  assign addr_written = wr_lane0 &&
    ((aw_addr_reg == break_unit_pkg::OFF_ADDR_HIGH) ||
     (aw_addr_reg == break_unit_pkg::OFF_ADDR_LOW));

  // RQ1: compare cpu address with break address
  assign addr_match = (cpu_in.addr == {addr_high_reg, addr_low_reg});
  // RQ18: no match while address is frozen in low power
  assign hw_match = enable_reg && armed_reg && cpu_in.addr_valid &&
    !cpu_in.low_power && addr_match &&
    (state_reg == break_unit_pkg::ST_IDLE);
  assign break_taken = hw_match ||
    (sw_trigger && (state_reg == break_unit_pkg::ST_IDLE));
  assign break_exit = (state_reg == break_unit_pkg::ST_BREAK) &&
    cpu_in.rti_done;

  // write address channel
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      s_axi_awready_out <= 1'b0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      // address taken, stop accepting
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
      s_axi_awready_out <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      // response done, free for next
      aw_held_reg <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held_reg && !s_axi_awready_out;
    end
  end

  // write data channel
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_wready_out <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      // data taken, stop accepting
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_in;
      w_strb_reg <= s_axi_wstrb_in;
      s_axi_wready_out <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      w_held_reg <= 1'b0;
    end else begin
      s_axi_wready_out <= !w_held_reg && !s_axi_wready_out;
    end
  end

  // write response
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= break_unit_pkg::RESP_OKAY;
    end else if (wr_do) begin
      // answer the cycle after both halves are held
      s_axi_bvalid_out <= 1'b1;
      if (is_mapped(aw_addr_reg)) begin
        s_axi_bresp_out <= break_unit_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp_out <= break_unit_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // RQ9: enable bit is read write and reset clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enable_reg <= 1'b0;
    end else if (wr_lane0 &&
        (aw_addr_reg == break_unit_pkg::OFF_STATUS_CONTROL)) begin
      enable_reg <= wr_byte[break_unit_pkg::BIT_ENABLE];
    end
  end

  // RQ10: active bit set by match, cleared by write zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_reg <= 1'b0;
    end else if (hw_match || sw_trigger) begin
      // set wins over a simultaneous clear
      active_reg <= 1'b1;
    end else if (sw_clear_active) begin
      active_reg <= 1'b0;
    end
  end

  // RQ12: break address bytes, cleared by reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_high_reg <= break_unit_pkg::RESET_BYTE;
      addr_low_reg <= break_unit_pkg::RESET_BYTE;
    end else if (wr_lane0) begin
      if (aw_addr_reg == break_unit_pkg::OFF_ADDR_HIGH) begin
        addr_high_reg <= wr_byte;
      end else if (aw_addr_reg == break_unit_pkg::OFF_ADDR_LOW) begin
        addr_low_reg <= wr_byte;
      end
    end
  end

  // RQ13: a hit disarms the address until it is rewritten
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      armed_reg <= 1'b1;
    end else if (addr_written) begin
      armed_reg <= 1'b1;
    end else if (hw_match) begin
      armed_reg <= 1'b0;
    end
  end

  // own control registers: mask and flag clear enable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_mask_reg <= break_unit_pkg::RESET_IRQ;
      flag_clear_enable_reg <= 1'b0;
    end else if (wr_lane0) begin
      if (aw_addr_reg == break_unit_pkg::OFF_IRQ_MASK) begin
        irq_mask_reg <= wr_byte[1:0];
      end else if (aw_addr_reg == break_unit_pkg::OFF_FLAG_CONTROL) begin
        flag_clear_enable_reg <= wr_byte[break_unit_pkg::BIT_FLAG_CLEAR_ENABLE];
      end
    end
  end

  // sticky event bits, write one to clear, set wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status_reg <= break_unit_pkg::RESET_IRQ;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == break_unit_pkg::BIT_IRQ_BREAK && break_taken) ||
            (i == break_unit_pkg::BIT_IRQ_EXIT && break_exit)) begin
          irq_status_reg[i] <= 1'b1;
        end else if (wr_lane0 && wr_byte[i] &&
            (aw_addr_reg == break_unit_pkg::OFF_IRQ_STATUS)) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt level from a flop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // break sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      break_unit_pkg::ST_IDLE: begin
        // RQ5: opcode hit replaces the fetched instruction now
        if (hw_match && cpu_in.opcode_fetch) begin
          state_next = break_unit_pkg::ST_FORCE;
        end else if (break_taken) begin
          // RQ6: operand hit lets the instruction finish
          // RQ7: software break waits for the next boundary
          state_next = break_unit_pkg::ST_PEND;
        end
      end
      break_unit_pkg::ST_PEND: begin
        // take the break at the instruction boundary
        if (cpu_in.instr_boundary) begin
          state_next = break_unit_pkg::ST_FORCE;
        end
      end
      break_unit_pkg::ST_FORCE: begin
        // one cycle of swi injection then routine runs
        state_next = break_unit_pkg::ST_BREAK;
      end
      break_unit_pkg::ST_BREAK: begin
        // RQ8: return from interrupt ends break state
        if (cpu_in.rti_done) begin
          state_next = break_unit_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = break_unit_pkg::ST_IDLE;
      end
    endcase
  end

  // break sequencer state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= break_unit_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // control toward cpu and system integration unit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      core_out.breakpoint_request <= 1'b0;
      core_out.force_swi <= 1'b0;
      core_out.vector_addr <= break_unit_pkg::VECTOR_USER;
      core_out.break_state <= 1'b0;
      core_out.timer_stop <= 1'b0;
      core_out.watchdog_disable <= 1'b0;
      core_out.flag_clear_allow <= 1'b1;
    end else begin
      // RQ1: request toward system integration unit
      core_out.breakpoint_request <= (state_next != break_unit_pkg::ST_IDLE);
      // RQ2: swi opcode forced into instruction register
      core_out.force_swi <= (state_next == break_unit_pkg::ST_FORCE);
      // RQ3: break vector by operating mode
      if (cpu_in.monitor_mode) begin
        core_out.vector_addr <= break_unit_pkg::VECTOR_MONITOR;
      end else begin
        core_out.vector_addr <= break_unit_pkg::VECTOR_USER;
      end
      core_out.break_state <= (state_next == break_unit_pkg::ST_BREAK) ||
        (state_next == break_unit_pkg::ST_FORCE);
      // RQ16: timer counter frozen during break
      core_out.timer_stop <= (state_next == break_unit_pkg::ST_BREAK) ||
        (state_next == break_unit_pkg::ST_FORCE);
      // RQ17: watchdog off in break with test voltage
      core_out.watchdog_disable <= cpu_in.test_high_voltage &&
        ((state_next == break_unit_pkg::ST_BREAK) ||
         (state_next == break_unit_pkg::ST_FORCE));
      // RQ15: module flags clearable in break only if enabled
      core_out.flag_clear_allow <= flag_clear_enable_reg ||
        !((state_next == break_unit_pkg::ST_BREAK) ||
          (state_next == break_unit_pkg::ST_FORCE));
    end
  end

  // read channel
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= break_unit_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      // answer the cycle after the address is taken
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= is_mapped(s_axi_araddr_in) ?
        break_unit_pkg::RESP_OKAY : break_unit_pkg::RESP_SLVERR;
      if (s_axi_araddr_in == break_unit_pkg::OFF_STATUS_CONTROL) begin
        s_axi_rdata_out <= {24'h00_0000, enable_reg, active_reg, 6'h00};
      end else if (s_axi_araddr_in == break_unit_pkg::OFF_ADDR_HIGH) begin
        s_axi_rdata_out <= {24'h00_0000, addr_high_reg};
      end else if (s_axi_araddr_in == break_unit_pkg::OFF_ADDR_LOW) begin
        s_axi_rdata_out <= {24'h00_0000, addr_low_reg};
      end else if (s_axi_araddr_in == break_unit_pkg::OFF_IRQ_STATUS) begin
        s_axi_rdata_out <= {30'h0, irq_status_reg};
      end else if (s_axi_araddr_in == break_unit_pkg::OFF_IRQ_MASK) begin
        s_axi_rdata_out <= {30'h0, irq_mask_reg};
      end else if (s_axi_araddr_in == break_unit_pkg::OFF_FLAG_CONTROL) begin
        s_axi_rdata_out <= {24'h00_0000, flag_clear_enable_reg, 7'h00};
      end else begin
        s_axi_rdata_out <= 32'h0000_0000;
      end
    end else if (s_axi_rvalid_out) begin
      // hold data until taken
      if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end else begin
      s_axi_arready_out <= !s_axi_arready_out;
    end
  end

endmodule

// ---- break_unit_pkg.sv ----
// constants, types and register map of the address breakpoint unit
// Operation
// RQ1: address equals break address with enable: request
// RQ2: break loads instruction register with swi
// RQ3: vector fffc/fffd user, fefc/fefd monitor
// RQ4: writing one to active bit triggers break
// RQ5: opcode match: instruction waits for routine
// RQ6: operand match: instruction completes first
// RQ7: software break taken before next instruction
// RQ8: return from interrupt ends break state
// RQ9: enable bit seven, read write, reset clear
// RQ10: active bit set on match, write zero clears
// RQ11: routine must clear active bit before return
// RQ12: address bytes held, reset to zero
// RQ13: unchanged address gives no repeated break
// RQ14: software should break on opcode addresses
// RQ15: flags clearable in break only with enable
// RQ16: timer counter stops during break state
// RQ17: watchdog off in break with test voltage
// RQ18: low power keeps enable, never triggers
package break_unit_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_FLAG_CONTROL = 8'h14;
  // field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_FLAG_CLEAR_ENABLE = 7;
  localparam int BIT_IRQ_BREAK = 0;
  localparam int BIT_IRQ_EXIT = 1;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_IRQ = 2'h0;
  // break vectors
  localparam logic [15:0] VECTOR_USER = 16'hFFFC;
  localparam logic [15:0] VECTOR_MONITOR = 16'hFEFC;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // break sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PEND = 4'b0010,
    ST_FORCE = 4'b0100,
    ST_BREAK = 4'b1000
  } break_state_t;
  // cpu bus status seen by the unit
  typedef struct packed {
    logic [15:0] addr;
    logic addr_valid;
    logic opcode_fetch;
    logic instr_boundary;
    logic rti_done;
    logic monitor_mode;
    logic low_power;
    logic test_high_voltage;
  } cpu_bus_t;
  // control toward cpu and system integration unit
  typedef struct packed {
    logic breakpoint_request;
    logic force_swi;
    logic [15:0] vector_addr;
    logic break_state;
    logic timer_stop;
    logic watchdog_disable;
    logic flag_clear_allow;
  } core_ctrl_t;
endpackage

// ---- break_unit_properties.sv ----
// port checker of the address breakpoint unit, bound to its top module
`timescale 1ns/1ps
module break_unit_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire break_unit_pkg::cpu_bus_t cpu_in,
  input wire break_unit_pkg::core_ctrl_t core_out
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // break state, request and timer stop dropped together
  sequence s_exit;
    !core_out.break_state && !core_out.breakpoint_request && !core_out.timer_stop;
  endsequence
  // forced opcode lasts one cycle
  sequence s_force_end;
    !core_out.force_swi;
  endsequence
  property p_force_pulse;
    core_out.force_swi |=> s_force_end;
  endproperty
  a_force_pulse: assert property (p_force_pulse) else $error("forced opcode longer than one cycle");
  property p_force_enters;
    core_out.force_swi |-> core_out.break_state && core_out.breakpoint_request;
  endproperty
  a_force_enters: assert property (p_force_enters) else $error("forced opcode outside break");
  // opcode hit, or pending break released at a boundary
  property p_force_cause;
    core_out.force_swi |-> $past(cpu_in.instr_boundary) || $past(cpu_in.opcode_fetch && cpu_in.addr_valid);
  endproperty
  a_force_cause: assert property (p_force_cause) else $error("break taken at wrong moment");
  property p_vector;
    core_out.force_swi |-> core_out.vector_addr == (cpu_in.monitor_mode ?
      break_unit_pkg::VECTOR_MONITOR : break_unit_pkg::VECTOR_USER);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong break vector");
  property p_timer;
    1'b1 |-> core_out.timer_stop == core_out.break_state;
  endproperty
  a_timer: assert property (p_timer) else $error("timer stop differs from break state");
  property p_watchdog;
    !core_out.break_state |-> !core_out.watchdog_disable;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog off outside break");
  property p_rti;
    core_out.break_state && cpu_in.rti_done |=> s_exit;
  endproperty
  a_rti: assert property (p_rti) else $error("break kept after return");
  property p_hold;
    core_out.break_state && !cpu_in.rti_done |=> core_out.break_state;
  endproperty
  a_hold: assert property (p_hold) else $error("break ended without return");
  property p_flag;
    !core_out.break_state && !$past(core_out.break_state) |-> core_out.flag_clear_allow;
  endproperty
  a_flag: assert property (p_flag) else $error("flag clearing blocked outside break");
  // bus answers stand until taken
  property p_bstand;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_bstand: assert property (p_bstand) else $error("write response dropped early");
  property p_rstand;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_rstand: assert property (p_rstand) else $error("read data dropped early");
  property p_rlat;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  c_force: cover property (core_out.force_swi);
endmodule

bind address_breakpoint_unit break_unit_properties break_unit_properties_i (
  .clk_in(clk_in), .rst_in(rst_in), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .s_axi_rdata_out(s_axi_rdata_out), .cpu_in(cpu_in), .core_out(core_out));

// ---- cpu_core_model.sv ----
// behavioural cpu core that walks addresses and returns from the break routine
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [15:0] start_in,
  input wire logic monitor_in,
  input wire logic low_power_in,
  input wire logic test_voltage_in,
  input wire logic rti_go_in,
  input wire break_unit_pkg::core_ctrl_t core_in,
  output break_unit_pkg::cpu_bus_t cpu_out
);
  logic [15:0] addr_reg; // current program address
  logic advance; // address moves this cycle
  assign advance = run_in && !load_in && !low_power_in && !core_in.break_state;
  // program counter, reloaded on request
  always_ff @(posedge clk_in) begin
    if (rst_in || load_in) begin
      addr_reg <= start_in;
    end else if (advance) begin
      addr_reg <= addr_reg + 16'h0001;
    end
  end
  // even opcodes, return only in break
  assign cpu_out = '{addr: addr_reg, addr_valid: advance, opcode_fetch: advance && !addr_reg[0],
    instr_boundary: advance && !addr_reg[0], rti_done: rti_go_in && core_in.break_state,
    monitor_mode: monitor_in, low_power: low_power_in, test_high_voltage: test_voltage_in};
endmodule

// ---- tb_top.sv ----
// register-level testbench of the address breakpoint unit
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0; // 200 mhz clock
  logic rst_in = 1'b1; // synchronous reset
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // master
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // bus addresses
  logic [31:0] wdata = 32'h0000_0000; // write data
  logic awready, wready, bvalid, arready, rvalid, irq; // slave answers
  logic [31:0] rdata; // read data
  logic [1:0] bresp, rresp; // responses
  logic run = 1'b0, load = 1'b0, mon = 1'b0, lp = 1'b0, tv = 1'b0, rti_go = 1'b0; // cpu control
  logic [15:0] start = 16'h0000; // cpu start address
  break_unit_pkg::cpu_bus_t cpu_bus; // cpu status
  break_unit_pkg::core_ctrl_t core_ctrl; // break control
  int n_errors = 0, checks = 0, n_force = 0; // counters
  address_breakpoint_unit address_breakpoint_unit_i (
    .clk_in(clk_in), .rst_in(rst_in), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .cpu_in(cpu_bus), .core_out(core_ctrl), .irq_out(irq));
  cpu_core_model cpu_core_model_i (
    .clk_in(clk_in), .rst_in(rst_in), .run_in(run), .load_in(load), .start_in(start),
    .monitor_in(mon), .low_power_in(lp), .test_voltage_in(tv), .rti_go_in(rti_go),
    .core_in(core_ctrl), .cpu_out(cpu_bus));
  // clock generator
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // counts forced opcodes
  always @(posedge clk_in) begin
    if (core_ctrl.force_swi === 1'b1) n_force <= n_force + 1;
  end
  // compares and reports
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_in);
      pa = pa && (awready !== 1'b1);
      pw = pw && (wready !== 1'b1);
      @(posedge clk_in);
      awvalid <= pa;
      wvalid <= pw;
    end
    bready <= 1'b1;
    do @(negedge clk_in); while (bvalid !== 1'b1);
    check({30'h0, bresp}, {30'h0, break_unit_pkg::RESP_OKAY});
    @(posedge clk_in);
    bready <= 1'b0;
  endtask
  // axi4-lite read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk_in); while (arready !== 1'b1);
    @(posedge clk_in);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge clk_in); while (rvalid !== 1'b1);
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
    @(posedge clk_in);
    rready <= 1'b0;
  endtask
  // restarts the cpu at an address with its modes
  task automatic go(input logic [15:0] s, input logic r, input logic m, input logic l,
    input logic t);
    @(posedge clk_in);
    start <= s;
    load <= 1'b1;
    run <= r;
    mon <= m;
    lp <= l;
    tv <= t;
    @(posedge clk_in);
    load <= 1'b0;
  endtask
  // waits a bounded time for the break state
  task automatic wait_break;
    int i = 0;
    while (core_ctrl.break_state !== 1'b1 && i < 40) begin
      @(negedge clk_in);
      i++;
    end
    check(core_ctrl.break_state, 1'b1);
  endtask
  // return from the break routine
  task automatic leave;
    @(posedge clk_in);
    rti_go <= 1'b1;
    @(posedge clk_in);
    rti_go <= 1'b0;
    @(negedge clk_in);
    check(core_ctrl.break_state, 1'b0);
  endtask
  // hang guard
  initial begin
    repeat (6000) @(posedge clk_in);
    n_errors++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0000, break_unit_pkg::RESP_OKAY);
    rd(break_unit_pkg::OFF_ADDR_HIGH, 32'h0000_0000, break_unit_pkg::RESP_OKAY);
    rd(break_unit_pkg::OFF_ADDR_LOW, 32'h0000_0000, break_unit_pkg::RESP_OKAY);
    rd(8'h20, 32'h0000_0000, break_unit_pkg::RESP_SLVERR);
    wr(break_unit_pkg::OFF_ADDR_HIGH, 32'h0000_0012);
    wr(break_unit_pkg::OFF_ADDR_LOW, 32'h0000_0034);
    rd(break_unit_pkg::OFF_ADDR_HIGH, 32'h0000_0012, break_unit_pkg::RESP_OKAY);
    rd(break_unit_pkg::OFF_ADDR_LOW, 32'h0000_0034, break_unit_pkg::RESP_OKAY);
    wr(break_unit_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080);
    rd(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080, break_unit_pkg::RESP_OKAY);
    // opcode hit in user mode
    go(16'h1230, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_break;
    check(core_ctrl.vector_addr, break_unit_pkg::VECTOR_USER);
    check(core_ctrl.timer_stop, 1'b1);
    check(core_ctrl.flag_clear_allow, 1'b0);
    check(core_ctrl.watchdog_disable, 1'b0);
    rd(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_00C0, break_unit_pkg::RESP_OKAY);
    check(n_force, 1);
    check(irq, 1'b1);
    wr(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080);
    rd(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080, break_unit_pkg::RESP_OKAY);
    leave;
    rd(break_unit_pkg::OFF_IRQ_STATUS, 32'h0000_0003, break_unit_pkg::RESP_OKAY);
    wr(break_unit_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    rd(break_unit_pkg::OFF_IRQ_STATUS, 32'h0000_0002, break_unit_pkg::RESP_OKAY);
    check(irq, 1'b0);
    // same address again without rewriting it
    go(16'h1230, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clk_in);
    check(n_force, 1);
    // operand hit in monitor mode with test voltage
    go(16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(break_unit_pkg::OFF_FLAG_CONTROL, 32'h0000_0080);
    wr(break_unit_pkg::OFF_ADDR_LOW, 32'h0000_0035);
    go(16'h1230, 1'b1, 1'b1, 1'b0, 1'b1);
    wait_break;
    check(core_ctrl.vector_addr, break_unit_pkg::VECTOR_MONITOR);
    check(core_ctrl.watchdog_disable, 1'b1);
    check(core_ctrl.flag_clear_allow, 1'b1);
    wr(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080);
    leave;
    // disabled: no hit
    go(16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0000);
    wr(break_unit_pkg::OFF_ADDR_LOW, 32'h0000_0034);
    go(16'h1230, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clk_in);
    check(n_force, 2);
    // low power holds the address on the break value
    wr(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080);
    go(16'h1234, 1'b1, 1'b0, 1'b1, 1'b0);
    repeat (20) @(posedge clk_in);
    check(n_force, 2);
    rd(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080, break_unit_pkg::RESP_OKAY);
    go(16'h1234, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_break;
    wr(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080);
    leave;
    // software requested break
    go(16'h2000, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_00C0);
    wait_break;
    rd(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_00C0, break_unit_pkg::RESP_OKAY);
    check(n_force, 4);
    wr(break_unit_pkg::OFF_STATUS_CONTROL, 32'h0000_0080);
    leave;
    end_of_test;
  end
endmodule
